// ---- rtl/mad_detector.sv ----
// Purpose: activity and inactivity detection with linked, loop and autosleep sequencing
// Assumes: sample_valid pulses once per output sample from logic on sys_clk
// Notes: flags are cleared by one-cycle pulses from the host; a new event beats a clear
`timescale 1ns/1ps
//
// Function
// - activity only after sustained over-threshold time
// - absolute activity compares raw sample to threshold
// - referenced activity uses deviation from reference
// - capture reference when activity enabled while measuring
// - linked: recapture reference on inactivity
// - unlinked: recapture reference on activity
// - activity timer and threshold programmable
// - wake-up mode uses single-sample activity
// - inactivity only after sustained under-threshold time
// - absolute inactivity needs consecutive samples under threshold
// - referenced inactivity uses deviation from reference
// - inactivity timer counts samples, one to 65535
// - any interruption restarts inactivity count
// - both detectors off after reset
// - default: both armed, pending event blocks re-signal
// - linked: after activity arm only inactivity
// - linked: after inactivity arm only activity
// - linked: wait for host service before rearming
// - loop: alternate without waiting for host
// - autosleep: wake-up on inactivity, measure on activity
// - default mode ignores autosleep
// - event flags, each routable to interrupts
// - awake flag set by activity, cleared by inactivity
// - wake-up mode evaluates about six samples per second
// - standby keeps flags, makes no new events
module mad_detector #(
   parameter int ACT_TW = mad_pkg::ACT_TIME_W,
   parameter int INACT_TW = mad_pkg::INACT_TIME_W,
   parameter int DECIM = mad_pkg::WAKE_DECIM
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic sample_valid,
   input wire logic [mad_pkg::SAMPLE_W-1:0] x_smp,
   input wire logic [mad_pkg::SAMPLE_W-1:0] y_smp,
   input wire logic [mad_pkg::SAMPLE_W-1:0] z_smp,
   input wire mad_pkg::mad_mode_type host_mode,
   input wire mad_pkg::mad_link_type link_mode,
   input wire logic autosleep_en,
   input wire logic act_en,
   input wire logic act_ref_mode,
   input wire logic [mad_pkg::THRESH_W-1:0] act_thresh,
   input wire logic [ACT_TW-1:0] act_time,
   input wire logic inact_en,
   input wire logic inact_ref_mode,
   input wire logic [mad_pkg::THRESH_W-1:0] inact_thresh,
   input wire logic [INACT_TW-1:0] inact_time,
   input wire logic act_clr,
   input wire logic inact_clr,
   input wire logic [mad_pkg::INT_MAP_W-1:0] int1_map,
   input wire logic [mad_pkg::INT_MAP_W-1:0] int2_map,
   output logic act_flag_q,
   output logic inact_flag_q,
   output logic awake_q,
   output logic auto_sleep_q,
   output logic int1_q,
   output logic int2_q
);
   import mad_pkg::*;

   localparam int DW = (DECIM > 1) ? $clog2(DECIM) : 1;
   localparam logic [DW-1:0] DEC_LAST = DW'(DECIM - 1);

   mad_state_type st_q;
   mad_state_type st_d;
   logic [DW-1:0] dec_q;
   logic [ACT_TW-1:0] act_cnt_q;
   logic [INACT_TW-1:0] inact_cnt_q;
   logic [SAMPLE_W-1:0] ref_x_q;
   logic [SAMPLE_W-1:0] ref_y_q;
   logic [SAMPLE_W-1:0] ref_z_q;
   logic cap_pend_q;
   logic act_on_q;
   logic inact_on_q;
   logic standby;
   logic eff_wake;
   logic linked;
   logic loop_m;
   logic eval;
   logic act_above;
   logic inact_below;
   logic act_armed;
   logic inact_armed;
   logic act_time_met;
   logic inact_time_met;
   logic act_det;
   logic inact_det;
   logic ref_cap;
   logic [INT_MAP_W-1:0] int_src;

   // mode decode; autosleep only pulls measurement into wake-up
   assign standby = (host_mode == MODE_STBY) || (host_mode == MODE_RSVD);
   assign eff_wake = (host_mode == MODE_WAKE) || ((host_mode == MODE_MEAS) && auto_sleep_q);
   assign loop_m = (link_mode == LINK_LOOP);
   assign linked = (link_mode == LINK_LINKED) || loop_m;

   // wake-up mode thins the evaluated samples; standby evaluates nothing
   assign eval = sample_valid && !standby && (!eff_wake || (dec_q == '0));

   // wake-up decimation counter
   always_ff @(posedge sys_clk) begin
      if (srst || !eff_wake) begin
         dec_q <= '0;
      end else if (sample_valid && !standby) begin
         dec_q <= (dec_q == DEC_LAST) ? '0 : DW'(dec_q + 1'b1);
      end
   end

   // comparators; a sample that takes a reference requested by an enable edge is judged against itself, not a stale one
   mad_axis_cmp u_act_cmp (
      .x_smp(x_smp),
      .y_smp(y_smp),
      .z_smp(z_smp),
      .x_ref(cap_pend_q ? x_smp : ref_x_q),
      .y_ref(cap_pend_q ? y_smp : ref_y_q),
      .z_ref(cap_pend_q ? z_smp : ref_z_q),
      .use_ref(act_ref_mode),
      .thresh(act_thresh),
      .any_above(act_above),
      .all_below()
   );

   mad_axis_cmp u_inact_cmp (
      .x_smp(x_smp),
      .y_smp(y_smp),
      .z_smp(z_smp),
      .x_ref(cap_pend_q ? x_smp : ref_x_q),
      .y_ref(cap_pend_q ? y_smp : ref_y_q),
      .z_ref(cap_pend_q ? z_smp : ref_z_q),
      .use_ref(inact_ref_mode),
      .thresh(inact_thresh),
      .any_above(),
      .all_below(inact_below)
   );

   // arming: default waits on the pending flag, linked and loop follow the sequencer
   assign act_armed = act_en && (linked ? (st_q == ST_LOOK_ACT) : !act_flag_q);
   assign inact_armed = inact_en && (linked ? (st_q == ST_LOOK_INACT) : !inact_flag_q);

   // qualification timers; a setting of zero behaves as one sample
   assign act_time_met = ({1'b0, act_cnt_q} + (ACT_TW + 1)'(1)) >= {1'b0, act_time};
   assign inact_time_met = ({1'b0, inact_cnt_q} + (INACT_TW + 1)'(1)) >= {1'b0, inact_time};
   assign act_det = eval && act_armed && act_above && (eff_wake || act_time_met);
   assign inact_det = eval && inact_armed && inact_below && inact_time_met;

   // activity sample counter, counts only in measurement mode
   always_ff @(posedge sys_clk) begin
      if (srst || !act_armed || eff_wake) begin
         act_cnt_q <= '0;
      end else if (eval) begin
         if (!act_above || act_det) begin
            act_cnt_q <= '0;
         end else if (act_cnt_q != '1) begin
            act_cnt_q <= ACT_TW'(act_cnt_q + 1'b1);
         end
      end
   end

   // inactivity sample counter, any moving sample restarts it
   always_ff @(posedge sys_clk) begin
      if (srst || !inact_armed) begin
         inact_cnt_q <= '0;
      end else if (eval) begin
         if (!inact_below || inact_det) begin
            inact_cnt_q <= '0;
         end else if (inact_cnt_q != '1) begin
            inact_cnt_q <= INACT_TW'(inact_cnt_q + 1'b1);
         end
      end
   end

   // event flags, a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         act_flag_q <= 1'b0;
         inact_flag_q <= 1'b0;
      end else begin
         if (act_det) begin
            act_flag_q <= 1'b1;
         end else if (act_clr) begin
            act_flag_q <= 1'b0;
         end
         if (inact_det) begin
            inact_flag_q <= 1'b1;
         end else if (inact_clr) begin
            inact_flag_q <= 1'b0;
         end
      end
   end

   // sequencer for linked and loop modes
   always_comb begin
      st_d = st_q;
      if (!linked) begin
         st_d = ST_LOOK_ACT;
      end else begin
         unique case (st_q)
            ST_LOOK_ACT: begin
               if (act_det) begin
                  st_d = loop_m ? ST_LOOK_INACT : ST_SERV_ACT;
               end
            end
            ST_SERV_ACT: begin
               if (loop_m || !act_flag_q) begin
                  st_d = ST_LOOK_INACT;
               end
            end
            ST_LOOK_INACT: begin
               if (inact_det) begin
                  st_d = loop_m ? ST_LOOK_ACT : ST_SERV_INACT;
               end
            end
            ST_SERV_INACT: begin
               if (loop_m || !inact_flag_q) begin
                  st_d = ST_LOOK_ACT;
               end
            end
         endcase
      end
   end

   // sequencer state
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= RST_STATE;
      end else begin
         st_q <= st_d;
      end
   end

   // awake status follows the last event
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         awake_q <= RST_AWAKE;
      end else if (act_det) begin
         awake_q <= 1'b1;
      end else if (inact_det) begin
         awake_q <= 1'b0;
      end
   end

   // autosleep drops to wake-up on inactivity and back on activity
   always_ff @(posedge sys_clk) begin
      if (srst || !linked || !autosleep_en) begin
         auto_sleep_q <= 1'b0;
      end else if (act_det) begin
         auto_sleep_q <= 1'b0;
      end else if (inact_det) begin
         auto_sleep_q <= 1'b1;
      end
   end

   // enable edges while measuring request a fresh reference
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         act_on_q <= 1'b0;
         inact_on_q <= 1'b0;
         cap_pend_q <= 1'b0;
      end else begin
         act_on_q <= act_en && !standby;
         inact_on_q <= inact_en && !standby;
         if ((act_en && !standby && !act_on_q) || (inact_en && !standby && !inact_on_q)) begin
            cap_pend_q <= 1'b1;
         end else if (ref_cap) begin
            cap_pend_q <= 1'b0;
         end
      end
   end

   // reference capture points
   assign ref_cap = eval && (cap_pend_q || (linked ? inact_det : act_det));

   // reference takes the sample in hand
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ref_x_q <= '0;
         ref_y_q <= '0;
         ref_z_q <= '0;
      end else if (ref_cap) begin
         ref_x_q <= x_smp;
         ref_y_q <= y_smp;
         ref_z_q <= z_smp;
      end
   end

   // interrupt routing
   assign int_src = {awake_q, inact_flag_q, act_flag_q};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         int1_q <= 1'b0;
         int2_q <= 1'b0;
      end else begin
         int1_q <= |(int1_map & int_src);
         int2_q <= |(int2_map & int_src);
      end
   end

   // checks on the detection logic
   property p_rst_clear;
      @(posedge sys_clk) srst |=> (!act_flag_q && !inact_flag_q && st_q == RST_STATE);
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("flags not clear after reset");
   property p_act_timed;
      @(posedge sys_clk) disable iff (srst)
      (act_det && !eff_wake) |-> (({1'b0, act_cnt_q} + (ACT_TW + 1)'(1)) >= {1'b0, act_time}) && act_above;
   endproperty
   a_act_timed: assert property (p_act_timed) else $error("activity declared early");
   property p_wake_single;
      @(posedge sys_clk) disable iff (srst)
      (eval && eff_wake && act_armed && act_above) |=> act_flag_q;
   endproperty
   a_wake_single: assert property (p_wake_single) else $error("wake-up activity not immediate");
   property p_inact_restart;
      @(posedge sys_clk) disable iff (srst)
      (eval && inact_armed && !inact_below) |=> (inact_cnt_q == '0);
   endproperty
   a_inact_restart: assert property (p_inact_restart) else $error("inactivity count not restarted");
   property p_linked_one;
      @(posedge sys_clk) disable iff (srst)
      linked |-> !(act_armed && inact_armed);
   endproperty
   a_linked_one: assert property (p_linked_one) else $error("both detectors armed in linked mode");
   property p_linked_wait;
      @(posedge sys_clk) disable iff (srst)
      (link_mode == LINK_LINKED && st_q == ST_SERV_ACT && act_flag_q && !act_clr) |=> (st_q == ST_SERV_ACT);
   endproperty
   a_linked_wait: assert property (p_linked_wait) else $error("rearmed before service");
   property p_autosleep;
      @(posedge sys_clk) disable iff (srst)
      (inact_det && linked && autosleep_en) ##1 (linked && autosleep_en) |-> auto_sleep_q;
   endproperty
   a_autosleep: assert property (p_autosleep) else $error("autosleep not entered");
   property p_default_nosleep;
      @(posedge sys_clk) disable iff (srst)
      (link_mode == LINK_DEFAULT) |=> !auto_sleep_q;
   endproperty
   a_default_nosleep: assert property (p_default_nosleep) else $error("autosleep in default mode");
   property p_standby_hold;
      @(posedge sys_clk) disable iff (srst)
      (standby && !act_clr && !inact_clr) |=> ($stable(act_flag_q) && $stable(inact_flag_q));
   endproperty
   a_standby_hold: assert property (p_standby_hold) else $error("flag changed in standby");

   property p_ref_sample;
      @(posedge sys_clk) disable iff (srst)
      ref_cap |=> (ref_x_q == $past(x_smp) && ref_y_q == $past(y_smp) && ref_z_q == $past(z_smp));
   endproperty
   a_ref_sample: assert property (p_ref_sample) else $error("reference not the captured sample");

   property p_set_wins;
      @(posedge sys_clk) disable iff (srst)
      (inact_det && inact_clr) |=> inact_flag_q ##1 (int2_q || !$past(int2_map[INT_BIT_INACT]));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

endmodule

// ---- rtl/mad_pkg.sv ----
// Purpose: shared types, field positions, reset values and helpers of the motion activity detector
// Assumes: samples are 12-bit two's complement, thresholds are unsigned magnitudes
// Notes: one reference set serves both detectors
package mad_pkg;

   // requested operating mode
   typedef enum logic [1:0] {
      MODE_STBY = 2'b00,
      MODE_RSVD = 2'b01,
      MODE_MEAS = 2'b10,
      MODE_WAKE = 2'b11
   } mad_mode_type;

   // how the two detectors interact
   typedef enum logic [1:0] {
      LINK_DEFAULT = 2'b00,
      LINK_LINKED = 2'b01,
      LINK_RSVD = 2'b10,
      LINK_LOOP = 2'b11
   } mad_link_type;

   // linked and loop sequencing, gray coded around the loop
   typedef enum logic [1:0] {
      ST_LOOK_ACT = 2'b00,
      ST_SERV_ACT = 2'b01,
      ST_LOOK_INACT = 2'b11,
      ST_SERV_INACT = 2'b10
   } mad_state_type;

   localparam int SAMPLE_W = 12;
   localparam int THRESH_W = 11;
   // 20 s at the slowest rate of 12.5 samples/s is 250 samples
   localparam int ACT_TIME_S = 20;
   localparam int ACT_TIME_W = 8;
   // up to 65535 samples
   localparam int INACT_TIME_W = 16;
   // wake-up mode evaluates one sample in this many, about six per second at 100 samples/s
   localparam int WAKE_DECIM = 16;

   // interrupt map field positions
   localparam int INT_MAP_W = 3;
   localparam int INT_BIT_ACT = 0;
   localparam int INT_BIT_INACT = 1;
   localparam int INT_BIT_AWAKE = 2;

   // values after reset
   localparam logic RST_AWAKE = 1'b0;
   localparam mad_state_type RST_STATE = ST_LOOK_ACT;

   // magnitude of a minus b, both signed samples
   function automatic logic [SAMPLE_W-1:0] abs_diff(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
      logic [SAMPLE_W:0] d;
      d = {a[SAMPLE_W-1], a} - {b[SAMPLE_W-1], b};
      abs_diff = d[SAMPLE_W] ? SAMPLE_W'(-d) : d[SAMPLE_W-1:0];
   endfunction

endpackage

// ---- rtl/mad_axis_cmp.sv ----
// Purpose: per-axis threshold comparison, absolute or against a reference
// Assumes: all inputs from the same clock domain, purely combinational
// Notes: any axis over the threshold counts as over; all axes must be under to count as under
`timescale 1ns/1ps
module mad_axis_cmp (
   input wire logic [mad_pkg::SAMPLE_W-1:0] x_smp,
   input wire logic [mad_pkg::SAMPLE_W-1:0] y_smp,
   input wire logic [mad_pkg::SAMPLE_W-1:0] z_smp,
   input wire logic [mad_pkg::SAMPLE_W-1:0] x_ref,
   input wire logic [mad_pkg::SAMPLE_W-1:0] y_ref,
   input wire logic [mad_pkg::SAMPLE_W-1:0] z_ref,
   input wire logic use_ref,
   input wire logic [mad_pkg::THRESH_W-1:0] thresh,
   output logic any_above,
   output logic all_below
);
   import mad_pkg::*;

   logic [SAMPLE_W-1:0] mag_x;
   logic [SAMPLE_W-1:0] mag_y;
   logic [SAMPLE_W-1:0] mag_z;
   logic [SAMPLE_W-1:0] thr_w;

   // magnitude per axis, deviation from reference when referenced
   assign mag_x = abs_diff(x_smp, use_ref ? x_ref : '0);
   assign mag_y = abs_diff(y_smp, use_ref ? y_ref : '0);
   assign mag_z = abs_diff(z_smp, use_ref ? z_ref : '0);
   assign thr_w = {1'b0, thresh};

   // each axis judged on its own
   assign any_above = (mag_x > thr_w) || (mag_y > thr_w) || (mag_z > thr_w);
   assign all_below = (mag_x < thr_w) && (mag_y < thr_w) && (mag_z < thr_w);
endmodule

// ---- verification/mad_host_model.sv ----
// Purpose: host side model that reads and clears pending activity and inactivity flags
// Assumes: flags are sticky and drop the edge after a one-cycle clear pulse
// Notes: dly sets how long the host waits before servicing, zero is prompt
`timescale 1ns/1ps
module mad_host_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic en,
   input wire logic [3:0] dly,
   input wire logic act_flag_q,
   input wire logic inact_flag_q,
   output logic act_clr,
   output logic inact_clr
);
   logic [1:0] flag;
   logic [1:0] clr = 2'b00;
   logic [3:0] cnt [2];
   assign flag = {inact_flag_q, act_flag_q};
   assign act_clr = clr[0];
   assign inact_clr = clr[1];
   // a flag seen pending is read, then cleared by one pulse; no pulse while nothing is pending
   always @(negedge sys_clk) begin
      for (int k = 0; k < 2; k++) begin
         if (srst || !en) begin
            clr[k] <= 1'b0;
            cnt[k] <= 4'h0;
         end else if (clr[k]) begin
            clr[k] <= 1'b0;
         end else if (flag[k] && cnt[k] >= dly) begin
            clr[k] <= 1'b1;
            cnt[k] <= 4'h0;
         end else begin
            cnt[k] <= flag[k] ? cnt[k] + 4'h1 : 4'h0;
         end
      end
   end
endmodule

// ---- verification/test_mad_detector.sv ----
// Purpose: self-checking bench of the motion activity detector
// Assumes: int1 routes the activity flag, int2 the inactivity flag and awake
// Notes: samples are random around a base; one random axis is pushed well over the activity threshold
`timescale 1ns/1ps
module test_mad_detector;
   import mad_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic sample_valid = 1'b0;
   logic [SAMPLE_W-1:0] x_smp = 12'h000, y_smp = 12'h000, z_smp = 12'h000;
   mad_mode_type host_mode = MODE_STBY;
   mad_link_type link_mode = LINK_DEFAULT;
   logic autosleep_en = 1'b0, act_en = 1'b0, act_ref_mode = 1'b0, inact_en = 1'b0, inact_ref_mode = 1'b0;
   logic [THRESH_W-1:0] act_thresh = 11'h0c8, inact_thresh = 11'h064;
   logic [7:0] act_time = 8'h03;
   logic [15:0] inact_time = 16'h0004;
   logic [2:0] int1_map = 3'h1, int2_map = 3'h6;
   logic act_clr, inact_clr, act_flag_q, inact_flag_q, awake_q, auto_sleep_q, int1_q, int2_q;
   logic host_en = 1'b0;
   logic [3:0] host_dly = 4'h0;
   logic [31:0] lfsr = 32'h9116;
   int n_fail = 0;
   int tests_run = 0;

   // clock of 8 ns
   always #4 sys_clk = ~sys_clk;

   mad_detector #(.DECIM(2)) dut (.sys_clk(sys_clk), .srst(srst), .sample_valid(sample_valid), .x_smp(x_smp),
      .y_smp(y_smp), .z_smp(z_smp), .host_mode(host_mode), .link_mode(link_mode), .autosleep_en(autosleep_en),
      .act_en(act_en), .act_ref_mode(act_ref_mode), .act_thresh(act_thresh), .act_time(act_time),
      .inact_en(inact_en), .inact_ref_mode(inact_ref_mode), .inact_thresh(inact_thresh), .inact_time(inact_time),
      .act_clr(act_clr), .inact_clr(inact_clr), .int1_map(int1_map), .int2_map(int2_map),
      .act_flag_q(act_flag_q), .inact_flag_q(inact_flag_q), .awake_q(awake_q), .auto_sleep_q(auto_sleep_q),
      .int1_q(int1_q), .int2_q(int2_q));

   mad_host_model host (.sys_clk(sys_clk), .srst(srst), .en(host_en), .dly(host_dly), .act_flag_q(act_flag_q),
      .inact_flag_q(inact_flag_q), .act_clr(act_clr), .inact_clr(inact_clr));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected outputs: flags, awake, autosleep, then the two interrupt lines through their maps
   function automatic logic [5:0] ex(input logic a, input logic i, input logic w, input logic s);
      return {a, i, w, s, a, i | w};
   endfunction

   task automatic conclude;
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [5:0] exp);
      logic [5:0] got;
      got = {act_flag_q, inact_flag_q, awake_q, auto_sleep_q, int1_q, int2_q};
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: outputs %b, expected %b", $time, got, exp);
      end
   endtask

   // one sample pulse, then a gap that lets flags and interrupts settle
   task automatic put(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
      @(negedge sys_clk);
      x_smp = x;
      y_smp = y;
      z_smp = z;
      sample_valid = 1'b1;
      @(negedge sys_clk);
      sample_valid = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   // samples near base; when over is set, one random axis moves 240 to 303 away in a random direction
   task automatic smp(input int n, input logic [11:0] base, input logic over);
      logic [11:0] v [3];
      logic [1:0] ax;
      repeat (n) begin
         lfsr = lfsr_next(lfsr);
         ax = lfsr[9:8] % 2'h3;
         for (int k = 0; k < 3; k++) v[k] = base + 12'(lfsr[5:0]) - 12'h020;
         if (over) v[ax] = lfsr[16] ? base + 12'h0f0 + 12'(lfsr[15:10]) : base - 12'h0f0 - 12'(lfsr[15:10]);
         put(v[0], v[1], v[2]);
      end
   endtask

   // let the host clear whatever is pending, at a random pace
   task automatic service;
      lfsr = lfsr_next(lfsr);
      host_dly <= lfsr[3:0];
      host_en <= 1'b1;
      repeat (20) @(negedge sys_clk);
      host_en <= 1'b0;
   endtask

   // watchdog far beyond the expected run of about 380 cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      conclude;
   end

   initial begin
      repeat (8) @(negedge sys_clk);
      srst = 1'b0;
      chk(ex(0, 0, 0, 0));
      host_mode = MODE_MEAS;
      smp(3, 12'h000, 1'b1);
      chk(ex(0, 0, 0, 0));
      act_en = 1'b1;
      smp(2, 12'h000, 1'b1);
      smp(1, 12'h000, 1'b0);
      smp(2, 12'h000, 1'b1);
      chk(ex(0, 0, 0, 0));
      smp(1, 12'h000, 1'b1);
      chk(ex(1, 0, 1, 0));
      smp(2, 12'h000, 1'b1);
      service;
      smp(1, 12'h000, 1'b1);
      chk(ex(0, 0, 1, 0));
      smp(2, 12'h000, 1'b1);
      chk(ex(1, 0, 1, 0));
      inact_en = 1'b1;
      smp(3, 12'h000, 1'b0);
      smp(1, 12'h000, 1'b1);
      smp(3, 12'h000, 1'b0);
      chk(ex(1, 0, 1, 0));
      smp(1, 12'h000, 1'b0);
      chk(ex(1, 1, 0, 0));
      service;
      host_mode = MODE_STBY;
      smp(4, 12'h000, 1'b1);
      chk(ex(0, 0, 0, 0));
      // referenced activity: reference taken from the first sample after enabling
      act_en = 1'b0;
      inact_en = 1'b0;
      host_mode = MODE_MEAS;
      act_ref_mode = 1'b1;
      act_time = 8'h00;
      @(negedge sys_clk);
      act_en = 1'b1;
      smp(4, 12'h300, 1'b0);
      chk(ex(0, 0, 0, 0));
      smp(1, 12'h300, 1'b1);
      chk(ex(1, 0, 1, 0));
      service;
      put(x_smp, y_smp, z_smp);
      chk(ex(0, 0, 1, 0));
      // referenced inactivity far from zero
      act_en = 1'b0;
      inact_ref_mode = 1'b1;
      inact_time = 16'h0002;
      @(negedge sys_clk);
      inact_en = 1'b1;
      smp(3, 12'h300, 1'b0);
      chk(ex(0, 1, 0, 0));
      service;
      // linked: one detector at a time, rearmed only after servicing
      act_ref_mode = 1'b0;
      inact_ref_mode = 1'b0;
      act_en = 1'b1;
      link_mode = LINK_LINKED;
      smp(3, 12'h000, 1'b0);
      chk(ex(0, 0, 0, 0));
      smp(1, 12'h000, 1'b1);
      chk(ex(1, 0, 1, 0));
      smp(3, 12'h000, 1'b0);
      chk(ex(1, 0, 1, 0));
      service;
      smp(2, 12'h000, 1'b0);
      chk(ex(0, 1, 0, 0));
      smp(1, 12'h000, 1'b1);
      chk(ex(0, 1, 0, 0));
      // loop with autosleep, no servicing
      link_mode = LINK_DEFAULT;
      service;
      link_mode = LINK_LOOP;
      autosleep_en = 1'b1;
      act_time = 8'h03;
      smp(3, 12'h000, 1'b1);
      chk(ex(1, 0, 1, 0));
      smp(2, 12'h000, 1'b0);
      chk(ex(1, 1, 0, 1));
      smp(2, 12'h000, 1'b1);
      chk(ex(1, 1, 1, 0));
      // default mode ignores autosleep
      link_mode = LINK_DEFAULT;
      service;
      smp(2, 12'h000, 1'b0);
      chk(ex(0, 1, 0, 0));
      // wake-up: only every second sample is judged, and one over sample is enough
      host_mode = MODE_WAKE;
      smp(1, 12'h000, 1'b0);
      smp(1, 12'h000, 1'b1);
      chk(ex(0, 1, 0, 0));
      smp(1, 12'h000, 1'b1);
      chk(ex(1, 1, 1, 0));
      conclude;
   end
endmodule
